//--- core/device_config_register_one.sv
/*
  Device configuration register one: one 32-bit register holding monitor
  select, dither mode, serial target address, write-only lock key, serial
  pin drive, pull-up enable and supply range.
  Every field leaves the block as a registered level, so the monitor
  switch, the dither generator and the pin pads downstream never see a
  combinational glitch while software rewrites the word.
  The key never lands in the stored word: it is latched apart and strobed
  for one cycle, so a lock controller sees every write, a repeat too.
  The parity bit is only stored; checking it is left to the caller.
  The one-hot source choice and the undefined-range flag are decoded
  from the stored word and so trail the fields by one cycle.
  Assumes a same-clock plain register port; read data one cycle later.
  Assumes the master never raises the write and read strobes together.
  Assumes a lock controller and the analog blocks sit outside.
*/
`timescale 1ns/1ns
`default_nettype none
module device_config_register_one (
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  input  wire logic [cfg_one_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]                    wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [31:0]                    rdata,
  output logic      [1:0]                     monitor_output_select,
  output logic      [3:0]                     monitor_source_onehot,
  output logic                                dither_random,
  output logic      [6:0]                     serial_target_address,
  output logic      [14:0]                    lock_key,
  output logic                                lock_key_strobe,
  output logic      [1:0]                     serial_pin_drive,
  output logic                                pullup_enable,
  output logic      [1:0]                     supply_range_select,
  output logic                                supply_range_undefined
);
  // whole block state in one flop bank; read data and decodes ride along
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] rdata;
    logic [14:0] key;
    logic        key_stb;
    logic [3:0]  onehot;
    logic        undef;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic   [3:0] dec_onehot;
  logic         dec_undef;
  logic         hit;

  // only the one word offset answers
  function automatic logic offset_hit(input logic [cfg_one_pkg::ADDR_W-1:0] a);
    logic match;
    match = (a == cfg_one_pkg::CFG_ONE_OFFSET);
    return match;
  endfunction

  // parity bit of a register word
  function automatic logic parity_field(input logic [31:0] word);
    logic par;
    par = word[cfg_one_pkg::PARITY_BIT];
    return par;
  endfunction

  // monitor selector of a register word
  function automatic logic [1:0] monitor_field(input logic [31:0] word);
    logic [1:0] sel;
    sel = word[cfg_one_pkg::MON_HI:cfg_one_pkg::MON_LO];
    return sel;
  endfunction

  // dither pattern bit of a register word
  function automatic logic dither_field(input logic [31:0] word);
    logic pat;
    pat = word[cfg_one_pkg::DITHER_BIT];
    return pat;
  endfunction

  // serial target address of a register word
  function automatic logic [6:0] target_field(input logic [31:0] word);
    logic [6:0] taddr;
    taddr = word[cfg_one_pkg::TADDR_HI:cfg_one_pkg::TADDR_LO];
    return taddr;
  endfunction

  // lock key of a register word
  function automatic logic [14:0] key_field(input logic [31:0] word);
    logic [14:0] key;
    key = word[cfg_one_pkg::KEY_HI:cfg_one_pkg::KEY_LO];
    return key;
  endfunction

  // pin drive code of a register word
  function automatic logic [1:0] drive_field(input logic [31:0] word);
    logic [1:0] drv;
    drv = word[cfg_one_pkg::DRIVE_HI:cfg_one_pkg::DRIVE_LO];
    return drv;
  endfunction

  // pull-up enable bit of a register word
  function automatic logic pullup_field(input logic [31:0] word);
    logic pu;
    pu = word[cfg_one_pkg::PULLUP_BIT];
    return pu;
  endfunction

  // supply range code of a register word
  function automatic logic [1:0] range_field(input logic [31:0] word);
    logic [1:0] rng;
    rng = word[cfg_one_pkg::RANGE_HI:cfg_one_pkg::RANGE_LO];
    return rng;
  endfunction

  // stored view, built field by field so key and reserved bit stay out
  function automatic logic [31:0] store_view(input logic [31:0] word);
    logic [31:0] view;
    view = cfg_one_pkg::CFG_ONE_RESET;
    view[cfg_one_pkg::PARITY_BIT] = parity_field(word);
    view[cfg_one_pkg::RSVD_BIT] = 1'b0;
    view[cfg_one_pkg::MON_HI:cfg_one_pkg::MON_LO] = monitor_field(word);
    view[cfg_one_pkg::DITHER_BIT] = dither_field(word);
    view[cfg_one_pkg::TADDR_HI:cfg_one_pkg::TADDR_LO] = target_field(word);
    view[cfg_one_pkg::KEY_HI:cfg_one_pkg::KEY_LO] = 15'h0000;
    view[cfg_one_pkg::DRIVE_HI:cfg_one_pkg::DRIVE_LO] = drive_field(word);
    view[cfg_one_pkg::PULLUP_BIT] = pullup_field(word);
    view[cfg_one_pkg::RANGE_HI:cfg_one_pkg::RANGE_LO] = range_field(word);
    // masked once more so a slip above cannot expose the key
    return view & cfg_one_pkg::STORE_MASK;
  endfunction

  // decoder works on the stored value so outputs stay registered
  // costs one cycle of lag on the one-hot and the undefined flag
  cfg_one_decode u_decode (
    .monitor_output_select (monitor_field(state_reg.cfg)),
    .supply_range_select   (range_field(state_reg.cfg)),
    .source_onehot         (dec_onehot),
    .range_undefined       (dec_undef)
  );

  assign hit = offset_hit(addr);

  // next state: read bus quiet unless a read hits
  // strobes may come back to back; both work on the stored word,
  // so a read right after a write already sees the new value
  always_comb begin
    state_next         = state_reg;
    state_next.key_stb = 1'b0;
    state_next.rdata   = cfg_one_pkg::READ_ZERO;
    state_next.onehot  = dec_onehot;
    state_next.undef   = dec_undef;
    if (wr && hit) begin
      // key not stored in readable bits
      state_next.cfg     = store_view(wdata);
      state_next.key     = key_field(wdata);
      state_next.key_stb = 1'b1; // pulse lets the lock logic see each write
    end
    if (rd && hit) begin
      state_next.rdata = store_view(state_reg.cfg);
    end
  end

  // zero reset
  // constants only in the reset branch; the decodes restart from zero
  // and pick up the stored word on the first edge after release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg.cfg     <= cfg_one_pkg::CFG_ONE_RESET;
      state_reg.rdata   <= cfg_one_pkg::READ_ZERO;
      state_reg.key     <= 15'h0000;
      state_reg.key_stb <= 1'b0;
      state_reg.onehot  <= 4'h0;
      state_reg.undef   <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // field outputs straight from flops
  assign rdata                  = state_reg.rdata;
  // one extraction per field, shared with the write path
  // monitor select
  assign monitor_output_select  = monitor_field(state_reg.cfg);
  assign monitor_source_onehot  = state_reg.onehot; // lags select by one cycle
  assign dither_random          = dither_field(state_reg.cfg);
  assign serial_target_address  = target_field(state_reg.cfg);
  // key and its strobe go only to the lock controller
  assign lock_key               = state_reg.key;
  assign lock_key_strobe        = state_reg.key_stb;
  // pin drive code; code 3 is the strongest, not the weakest
  assign serial_pin_drive       = drive_field(state_reg.cfg);
  assign pullup_enable          = pullup_field(state_reg.cfg);
  // supply range; code 3 also raises the undefined flag
  assign supply_range_select    = range_field(state_reg.cfg);
  assign supply_range_undefined = state_reg.undef;
endmodule
`default_nettype wire

//--- inc/cfg_one_pkg.sv
/*
  Constants for the device configuration register one: offset, field
  positions, reset value and field codes.
  Assumes a plain address/strobe register port with 8-bit word addresses.
*/
package cfg_one_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  CFG_ONE_OFFSET  = 8'hA6;
  localparam logic [31:0] CFG_ONE_RESET   = 32'h00000000;
  localparam logic [31:0] READ_ZERO       = 32'h00000000;
  // field positions
  localparam int PARITY_BIT  = 31;
  localparam int RSVD_BIT    = 30;
  localparam int MON_HI      = 29;
  localparam int MON_LO      = 28;
  localparam int DITHER_BIT  = 27;
  localparam int TADDR_HI    = 26;
  localparam int TADDR_LO    = 20;
  localparam int KEY_HI      = 19;
  localparam int KEY_LO      = 5;
  localparam int DRIVE_HI    = 4;
  localparam int DRIVE_LO    = 3;
  localparam int PULLUP_BIT  = 2;
  localparam int RANGE_HI    = 1;
  localparam int RANGE_LO    = 0;
  // readable and writable bits: all but reserved bit 30 and the key
  localparam logic [31:0] STORE_MASK = 32'hBFF0001F;
  // monitor output source codes
  localparam logic [1:0] MON_CONV_CH2 = 2'h0;
  localparam logic [1:0] MON_PHASE_A  = 2'h1;
  localparam logic [1:0] MON_PHASE_B  = 2'h2;
  localparam logic [1:0] MON_PHASE_C  = 2'h3;
  // supply range codes
  localparam logic [1:0] RANGE_UNDEF  = 2'h3;
endpackage

//--- core/cfg_one_decode.sv
/*
  Decoder turning the monitor output selector into a one-hot source choice
  and flagging an undefined supply range code.
  Assumes same-clock inputs; purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
module cfg_one_decode (
  input  wire logic [1:0] monitor_output_select,
  input  wire logic [1:0] supply_range_select,
  output logic      [3:0] source_onehot,
  output logic            range_undefined
);
  always_comb begin
    source_onehot = 4'h0;
    case (monitor_output_select)
      cfg_one_pkg::MON_CONV_CH2: source_onehot = 4'h1;
      cfg_one_pkg::MON_PHASE_A:  source_onehot = 4'h2;
      cfg_one_pkg::MON_PHASE_B:  source_onehot = 4'h4;
      cfg_one_pkg::MON_PHASE_C:  source_onehot = 4'h8;
      default:                   source_onehot = 4'h0;
    endcase
  end
  assign range_undefined = (supply_range_select == cfg_one_pkg::RANGE_UNDEF);
endmodule
`default_nettype wire

//--- testbench/cfg_one_properties.sv
/* Checker on the ports of configuration register one.
   Assumes one clock and strobes that never overlap. */
`timescale 1ns/1ns
`default_nettype none
module cfg_one_properties (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  monitor_output_select,
  input wire logic [3:0]  monitor_source_onehot,
  input wire logic        dither_random,
  input wire logic [6:0]  serial_target_address,
  input wire logic [14:0] lock_key,
  input wire logic        lock_key_strobe,
  input wire logic [1:0]  serial_pin_drive,
  input wire logic        pullup_enable,
  input wire logic [1:0]  supply_range_select,
  input wire logic        supply_range_undefined
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // stored fields as they sit in bits 29 to 0
  wire logic [29:0] fld = {monitor_output_select, dither_random, serial_target_address,
    lock_key, serial_pin_drive, pullup_enable, supply_range_select};
  sequence s_wr; wr && addr == 8'hA6; endsequence
  a_write_fields: assert property (s_wr |=> fld == $past(wdata[29:0]))
    else $error("field write");
  a_write_strobe: assert property (s_wr |=> lock_key_strobe)
    else $error("no strobe");
  a_fields_hold: assert property (!(wr && addr == 8'hA6) |=> $stable(fld))
    else $error("field moved");
  a_read_fields: assert property (rd && addr == 8'hA6 |=> rdata[29:20] == fld[29:20]
    && rdata[4:0] == fld[4:0]) else $error("read data");
  a_read_quiet: assert property (!(rd && addr == 8'hA6) |=> rdata == 32'h0)
    else $error("stray read data");
  a_hidden_zero: assert property (rdata[19:5] == 15'h0 && !rdata[30])
    else $error("hidden bits seen");
  // decodes trail the stored select by one cycle, also across back-to-back writes
  a_onehot_map: assert property ($past(reset_n) |->
    monitor_source_onehot == 4'h1 << $past(monitor_output_select)) else $error("onehot");
  a_range_flag: assert property ($past(reset_n) |->
    supply_range_undefined == ($past(supply_range_select) == 2'h3)) else $error("range flag");
  a_strobe_quiet: assert property (!(wr && addr == 8'hA6) |=> !lock_key_strobe)
    else $error("stray strobe");
endmodule
bind device_config_register_one cfg_one_properties chk (.*);
`default_nettype wire

//--- testbench/device_config_register_one_test.sv
/* Bench for configuration register one: bus tasks and field checks.
   Assumes the checker file is compiled with it. */
`timescale 1ns/1ns
`default_nettype none
module device_config_register_one_test;
  logic        clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, w;
  logic [1:0]  monitor_output_select, serial_pin_drive, supply_range_select;
  logic [3:0]  monitor_source_onehot;
  logic [6:0]  serial_target_address;
  logic [14:0] lock_key;
  logic        dither_random, lock_key_strobe, pullup_enable, supply_range_undefined;
  int          failures = 0, num_checks = 0;
  device_config_register_one dut (
    .clk                    (clk),
    .reset_n                (reset_n),
    .addr                   (addr),
    .wdata                  (wdata),
    .wr                     (wr),
    .rd                     (rd),
    .rdata                  (rdata),
    .monitor_output_select  (monitor_output_select),
    .monitor_source_onehot  (monitor_source_onehot),
    .dither_random          (dither_random),
    .serial_target_address  (serial_target_address),
    .lock_key               (lock_key),
    .lock_key_strobe        (lock_key_strobe),
    .serial_pin_drive       (serial_pin_drive),
    .pullup_enable          (pullup_enable),
    .supply_range_select    (supply_range_select),
    .supply_range_undefined (supply_range_undefined)
  );
  always #2 clk = ~clk;
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd_reg(8'hA6, 32'h0);
    chk("reset", 32'h0, {2'h0, monitor_output_select, dither_random, serial_target_address,
      lock_key, serial_pin_drive, pullup_enable, supply_range_select});
    // every code of each one- and two-bit field; reserved bit written as one, key as 7FF0 plus the index
    for (int i = 0; i < 4; i++) begin
      w = {1'(i), 1'b1, 2'(i), 1'(i), 7'h2A + 7'(i), 15'h7FF0 + 15'(i), 2'(i), 1'(i), 2'(i)};
      wr_reg(8'hA6, w);
      #1 chk("strobe", 32'h1, {31'h0, lock_key_strobe});
      chk("key", {17'h0, w[19:5]}, {17'h0, lock_key});
      rd_reg(8'hA6, w & 32'hBFF0001F);
      chk("fields", {17'h0, w[29:20], w[4:0]}, {17'h0, monitor_output_select, dither_random,
        serial_target_address, serial_pin_drive, pullup_enable, supply_range_select});
      chk("onehot", 32'h1 << i, {28'h0, monitor_source_onehot});
      chk("undef", {31'h0, i == 3}, {31'h0, supply_range_undefined});
    end
    // unmapped offset neither stores nor answers
    wr_reg(8'hA5, 32'hFFFFFFFF);
    #1 chk("strobe", 32'h0, {31'h0, lock_key_strobe});
    chk("key", {17'h0, w[19:5]}, {17'h0, lock_key});
    rd_reg(8'hA5, 32'h0);
    rd_reg(8'hA6, w & 32'hBFF0001F);
    // reset in mid-run, driven on the edge, clears every field
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    rd_reg(8'hA6, 32'h0);
    chk("reset", 32'h0, {2'h0, monitor_output_select, dither_random, serial_target_address,
      lock_key, serial_pin_drive, pullup_enable, supply_range_select});
    chk("onehot", 32'h1, {28'h0, monitor_source_onehot});
    chk("strobe", 32'h0, {31'h0, lock_key_strobe});
    tally_and_finish;
  end
  // run needs about 44 cycles
  initial begin
    #4000;
    failures++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
